/* File: hdl/bbdec_defs.svh */
// Opcode patterns, field positions and length constants for the opcode decoder
`ifndef BBDEC_DEFS_SVH
`define BBDEC_DEFS_SVH
`define BBDEC_W_BIT 0
`define BBDEC_D_BIT 1
`define BBDEC_S_BIT 1
`define BBDEC_V_BIT 1
`define BBDEC_MOD_HI 7
`define BBDEC_MOD_LO 6
`define BBDEC_REG_HI 5
`define BBDEC_REG_LO 3
`define BBDEC_RM_HI 2
`define BBDEC_RM_LO 0
`define BBDEC_BYTE_ASCII_ADJ 8'h37
`define BBDEC_BYTE_DEC_ADJ 8'h27
`define BBDEC_BYTE_FLAGS_TO_HI 8'h9f
`define BBDEC_BYTE_HI_TO_FLAGS 8'h9e
`define BBDEC_BYTE_TABLE_LOOKUP 8'hd7
`define BBDEC_BYTE_WIDEN_BYTE 8'h98
`define BBDEC_BYTE_WIDEN_WORD 8'h99
`define BBDEC_LEN_MAX 4'h6
`endif

/* File: hdl/bbdec_pkg.sv */
// Types shared by the opcode decoder files
package bbdec_pkg;
  typedef enum logic [4:0] {
    BBDEC_OP_NONE = 5'h00,
    BBDEC_OP_SWAP = 5'h01,
    BBDEC_OP_AND = 5'h02,
    BBDEC_OP_ADC = 5'h03,
    BBDEC_OP_SUB = 5'h04,
    BBDEC_OP_INC = 5'h05,
    BBDEC_OP_TEST = 5'h06,
    BBDEC_OP_MULU = 5'h07,
    BBDEC_OP_MULS = 5'h08,
    BBDEC_OP_DIVU = 5'h09,
    BBDEC_OP_DIVS = 5'h0a,
    BBDEC_OP_F2AH = 5'h0b,
    BBDEC_OP_AH2F = 5'h0c,
    BBDEC_OP_XLT = 5'h0d,
    BBDEC_OP_SXB = 5'h0e,
    BBDEC_OP_SXW = 5'h0f,
    BBDEC_OP_PIN = 5'h10,
    BBDEC_OP_SLD = 5'h11,
    BBDEC_OP_SST = 5'h12,
    BBDEC_OP_AAJ = 5'h13,
    BBDEC_OP_DAJ = 5'h14,
    BBDEC_OP_SHR = 5'h15
  } bbdec_op_t;
  typedef enum logic [1:0] {
    BBDEC_ST_OPC = 2'b00,
    BBDEC_ST_MRM = 2'b01,
    BBDEC_ST_TAIL = 2'b10
  } bbdec_state_t;
endpackage

/* File: hdl/bbdec_len.sv */
// Addressing-byte displacement length helper
`timescale 1ns/1ns
`default_nettype none
module bbdec_len (
  input wire logic [1:0] mode,
  input wire logic [2:0] rm,
  output logic [1:0] disp_len
);
  // mode 00 with rm 110 is a direct 16-bit address
  always_comb
  begin
    case (mode)
      2'b00: disp_len = (rm == 3'b110) ? 2'd2 : 2'd0;
      2'b01: disp_len = 2'd1;
      2'b10: disp_len = 2'd2;
      default: disp_len = 2'd0;
    endcase
  end
endmodule
`default_nettype wire

/* File: hdl/bbdec_top.sv */
// Opcode decoder: collects instruction bytes and reports operation and fields
// What this block does
// - Decode register and accumulator swap forms
// - Decode AND immediate to accumulator
// - Decode add-with-carry immediate, s:w 01 extra
// - Decode subtract immediate, s:w 01 extra
// - Decode increment, memory and register forms
// - Flag-only AND writes no result
// - Multiply unsigned or signed
// - Divide unsigned or signed
// - Flags copied into accumulator high byte
// - Accumulator high byte written to flags
// - Low byte replaced from table
// - Byte and word sign widening
// - Port read fixed or variable
// - String load and store via accumulator
// - Decode ascii and decimal add adjust
// - Width bit selects word or byte
// - Direction bit selects register as destination
// - s:w 11 sign-extends one byte
// - Count bit selects one or count register
`timescale 1ns/1ns
`default_nettype none
`include "bbdec_defs.svh"
module bbdec_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic byte_valid,
  output logic byte_ready,
  input wire logic [7:0] byte_data,
  output logic dec_valid,
  input wire logic dec_ready,
  output bbdec_pkg::bbdec_op_t dec_op,
  output logic dec_word,
  output logic dec_reg_dest,
  output logic dec_wb,
  output logic dec_flags_wr,
  output logic dec_signed,
  output logic dec_imm_sext,
  output logic dec_imm_valid,
  output logic [15:0] dec_imm,
  output logic [15:0] dec_disp,
  output logic dec_port_var,
  output logic dec_count_reg,
  output logic [1:0] dec_mode,
  output logic [2:0] dec_reg,
  output logic [2:0] dec_rm,
  output logic [3:0] dec_len
);
  import bbdec_pkg::*;

  bbdec_state_t state_q;
  logic [7:0] opc_q;
  logic [7:0] mrm_q;
  logic [2:0] need_q;
  logic [2:0] got_q;
  logic [1:0] dlen_q;
  logic [7:0] tail_q [0:3];
  logic done_q;
  logic [1:0] disp_len;
  logic take;

  // Opcode-level classification
  logic has_mrm;
  logic [1:0] imm_len;
  bbdec_op_t op_c;
  logic w_c;
  logic d_c;
  logic sext_c;
  logic port_var_c;
  logic cnt_c;

  // Holding the byte until the result is taken gives back-pressure to fetch
  assign take = byte_valid && byte_ready;
  assign byte_ready = !done_q;
  assign dec_valid = done_q;

  bbdec_len u_len (
    .mode(byte_data[`BBDEC_MOD_HI:`BBDEC_MOD_LO]),
    .rm(byte_data[`BBDEC_RM_HI:`BBDEC_RM_LO]),
    .disp_len(disp_len)
  );

  // Classification; live input only until a result is held, so idle bus data cannot disturb it
  always_comb
  begin
    logic [7:0] o;
    logic [2:0] mid;
    o = (state_q == BBDEC_ST_OPC && !done_q) ? byte_data : opc_q;
    mid = (state_q == BBDEC_ST_MRM && !done_q) ? byte_data[`BBDEC_REG_HI:`BBDEC_REG_LO]
                                                : mrm_q[`BBDEC_REG_HI:`BBDEC_REG_LO];
    has_mrm = 1'b0;
    imm_len = 2'd0;
    op_c = BBDEC_OP_NONE;
    w_c = o[`BBDEC_W_BIT];
    d_c = o[`BBDEC_D_BIT];
    sext_c = 1'b0;
    port_var_c = 1'b0;
    cnt_c = 1'b0;
    if (o[7:1] == 7'b1000011)
    begin
      op_c = BBDEC_OP_SWAP;
      has_mrm = 1'b1;
      d_c = 1'b1;
    end
    else if (o[7:3] == 5'b10010)
    begin
      op_c = BBDEC_OP_SWAP;
      w_c = 1'b1;
    end
    else if (o[7:1] == 7'b0010010)
      begin
        op_c = BBDEC_OP_AND;
        imm_len = w_c ? 2'd2 : 2'd1;
      end
    else if (o[7:1] == 7'b0001010)
    begin
      op_c = BBDEC_OP_ADC;
      imm_len = w_c ? 2'd2 : 2'd1;
    end
    else if (o[7:1] == 7'b0010110)
    begin
      op_c = BBDEC_OP_SUB;
      imm_len = w_c ? 2'd2 : 2'd1;
    end
    else if (o[7:2] == 6'b100000)
    begin
      has_mrm = 1'b1;
      // second byte only for s:w 01
      imm_len = (o[1:0] == 2'b01) ? 2'd2 : 2'd1;
      sext_c = (o[1:0] == 2'b11);
      d_c = 1'b0;
      case (mid)
        3'b010: op_c = BBDEC_OP_ADC;
        3'b101: op_c = BBDEC_OP_SUB;
        3'b100: op_c = BBDEC_OP_AND;
        default: op_c = BBDEC_OP_NONE;
      endcase
    end
    else if (o[7:1] == 7'b1111111)
    begin
      has_mrm = 1'b1;
      op_c = (mid == 3'b000) ? BBDEC_OP_INC : BBDEC_OP_NONE;
    end
    else if (o[7:3] == 5'b01000)
    begin
      op_c = BBDEC_OP_INC;
      w_c = 1'b1;
    end
    else if (o[7:1] == 7'b1000010)
    begin
      op_c = BBDEC_OP_TEST;
      has_mrm = 1'b1;
    end
    else if (o[7:1] == 7'b1010100)
    begin
      op_c = BBDEC_OP_TEST;
      imm_len = w_c ? 2'd2 : 2'd1;
    end
    else if (o[7:1] == 7'b1111011)
    begin
      has_mrm = 1'b1;
      case (mid)
        3'b000:
        begin
          op_c = BBDEC_OP_TEST;
          imm_len = w_c ? 2'd2 : 2'd1;
        end
        3'b100: op_c = BBDEC_OP_MULU;
        3'b101: op_c = BBDEC_OP_MULS;
        3'b110: op_c = BBDEC_OP_DIVU;
        3'b111: op_c = BBDEC_OP_DIVS;
        default: op_c = BBDEC_OP_NONE;
      endcase
    end
    // count bit for shifts and rotates
    else if (o[7:2] == 6'b110100)
    begin
      op_c = BBDEC_OP_SHR;
      has_mrm = 1'b1;
      cnt_c = o[`BBDEC_V_BIT];
    end
    else if ({o[7:4], o[2:1]} == 6'b111010)
    begin
      op_c = BBDEC_OP_PIN;
      port_var_c = o[3];
      imm_len = o[3] ? 2'd0 : 2'd1;
    end
    else if (o[7:1] == 7'b1010110)
      op_c = BBDEC_OP_SLD;
    else if (o[7:1] == 7'b1010101)
      op_c = BBDEC_OP_SST;
    else
    begin
      case (o)
        `BBDEC_BYTE_FLAGS_TO_HI: op_c = BBDEC_OP_F2AH;
        `BBDEC_BYTE_HI_TO_FLAGS: op_c = BBDEC_OP_AH2F;
        `BBDEC_BYTE_TABLE_LOOKUP: op_c = BBDEC_OP_XLT;
        `BBDEC_BYTE_WIDEN_BYTE: op_c = BBDEC_OP_SXB;
        `BBDEC_BYTE_WIDEN_WORD: op_c = BBDEC_OP_SXW;
        `BBDEC_BYTE_ASCII_ADJ: op_c = BBDEC_OP_AAJ;
        `BBDEC_BYTE_DEC_ADJ: op_c = BBDEC_OP_DAJ;
        default: op_c = BBDEC_OP_NONE;
      endcase
      w_c = (op_c == BBDEC_OP_SXB || op_c == BBDEC_OP_SXW) ? 1'b1 : w_c;
    end
  end

  // Byte collection sequence
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= BBDEC_ST_OPC;
      opc_q <= 8'h00;
      mrm_q <= 8'h00;
      need_q <= 3'd0;
      got_q <= 3'd0;
      dlen_q <= 2'd0;
      done_q <= 1'b0;
    end
    else if (done_q)
    begin
      if (dec_ready)
      begin
        done_q <= 1'b0;
        state_q <= BBDEC_ST_OPC;
      end
    end
    else if (take)
    begin
      case (state_q)
        BBDEC_ST_OPC:
        begin
          opc_q <= byte_data;
          mrm_q <= 8'h00;
          dlen_q <= 2'd0;
          got_q <= 3'd0;
          need_q <= {1'b0, imm_len};
          if (has_mrm)
            state_q <= BBDEC_ST_MRM;
          else if (imm_len != 2'd0)
            state_q <= BBDEC_ST_TAIL;
          else
            done_q <= 1'b1;
        end
        BBDEC_ST_MRM:
        begin
          mrm_q <= byte_data;
          dlen_q <= disp_len;
          need_q <= {1'b0, disp_len} + {1'b0, imm_len};
          if (({1'b0, disp_len} + {1'b0, imm_len}) == 3'd0)
            done_q <= 1'b1;
          else
            state_q <= BBDEC_ST_TAIL;
        end
        BBDEC_ST_TAIL:
        begin
          got_q <= got_q + 3'd1;
          if (got_q + 3'd1 == need_q)
            done_q <= 1'b1;
        end
        default: state_q <= BBDEC_ST_OPC;
      endcase
    end
  end

  // Displacement and immediate bytes, stored in arrival order
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
        tail_q[i] <= 8'h00;
    end
    else if (take && state_q == BBDEC_ST_TAIL)
      tail_q[got_q[1:0]] <= byte_data;
  end

  // Result fields; operands split by stored displacement length
  always_comb
  begin
    logic [7:0] i0;
    logic [7:0] i1;
    i0 = tail_q[dlen_q];
    i1 = tail_q[2'(dlen_q + 2'd1)];
    dec_op = op_c;
    dec_word = w_c;
    dec_reg_dest = d_c;
    // no writeback for flag-only AND, high byte to flags
    dec_wb = !(op_c == BBDEC_OP_TEST || op_c == BBDEC_OP_AH2F || op_c == BBDEC_OP_NONE);
    dec_flags_wr = !(op_c == BBDEC_OP_F2AH || op_c == BBDEC_OP_XLT || op_c == BBDEC_OP_SXB ||
                     op_c == BBDEC_OP_SXW || op_c == BBDEC_OP_PIN || op_c == BBDEC_OP_SLD ||
                     op_c == BBDEC_OP_SST || op_c == BBDEC_OP_SWAP || op_c == BBDEC_OP_NONE);
    dec_signed = (op_c == BBDEC_OP_MULS || op_c == BBDEC_OP_DIVS);
    dec_imm_sext = sext_c;
    dec_imm_valid = (need_q != {1'b0, dlen_q});
    if (need_q - {1'b0, dlen_q} == 3'd2)
      dec_imm = {i1, i0};
    else if (sext_c)
      dec_imm = {{8{i0[7]}}, i0};
    else
      dec_imm = {8'h00, i0};
    case (dlen_q)
      2'd1: dec_disp = {{8{tail_q[0][7]}}, tail_q[0]};
      2'd2: dec_disp = {tail_q[1], tail_q[0]};
      default: dec_disp = 16'h0000;
    endcase
    dec_port_var = port_var_c;
    dec_count_reg = cnt_c;
    dec_mode = mrm_q[`BBDEC_MOD_HI:`BBDEC_MOD_LO];
    dec_reg = (op_c == BBDEC_OP_INC && !has_mrm) || (op_c == BBDEC_OP_SWAP && !has_mrm)
              ? opc_q[2:0] : mrm_q[`BBDEC_REG_HI:`BBDEC_REG_LO];
    dec_rm = mrm_q[`BBDEC_RM_HI:`BBDEC_RM_LO];
    dec_len = 4'd1 + {3'd0, has_mrm} + {1'b0, need_q};
  end
endmodule
`default_nettype wire

/* File: dv/bbdec_feed.sv */
// Fetch-side model: offers queued instruction bytes to the decoder
`timescale 1ns/1ns
`default_nettype none
module bbdec_feed (
  input wire logic clk,
  input wire logic rst,
  input wire logic byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic [7:0] q[$];
  logic tk;
  logic nv;
  initial byte_valid = 1'b0;
  initial byte_data = 8'h00;
  // Handshake seen at the rising edge
  always @(posedge clk)
    tk <= byte_valid && byte_ready;
  // A byte on offer is held until taken; gaps only between bytes
  always @(negedge clk)
  begin
    nv = byte_valid && !tk;
    if (tk)
      void'(q.pop_front());
    if (!nv)
      nv = q.size() > 0 && $urandom_range(3) != 0;
    if (rst)
      nv = 1'b0;
    byte_valid <= nv;
    // Idle data toggles so a stale byte is never mistaken for a fresh one
    byte_data <= nv ? q[0] : ~byte_data;
  end
endmodule
`default_nettype wire

/* File: dv/bbdec_properties.sv */
// Port checker for the opcode decoder
`timescale 1ns/1ns
`default_nettype none
module bbdec_checker
  import bbdec_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic byte_valid,
  input wire logic byte_ready,
  input wire logic [7:0] byte_data,
  input wire logic dec_valid,
  input wire logic dec_ready,
  input wire bbdec_pkg::bbdec_op_t dec_op,
  input wire logic dec_word,
  input wire logic dec_wb,
  input wire logic dec_flags_wr,
  input wire logic dec_signed,
  input wire logic dec_imm_sext,
  input wire logic [15:0] dec_imm,
  input wire logic [2:0] dec_reg,
  input wire logic [3:0] dec_len
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic first_q;
  logic [3:0] cnt_q;
  logic op1;
  assign op1 = byte_valid && byte_ready && first_q;
  // Opcode position and byte count of the instruction in flight
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      first_q <= 1'b1;
      cnt_q <= 4'h0;
    end
    else if (byte_valid && byte_ready)
    begin
      first_q <= 1'b0;
      cnt_q <= first_q ? 4'h1 : cnt_q + 4'h1;
    end
    else if (dec_valid && dec_ready)
      first_q <= 1'b1;
  property p_adjust;
    op1 && (byte_data == 8'h37 || byte_data == 8'h27) |=> dec_valid && dec_len == 4'h1
      && dec_op == ($past(byte_data[4]) ? BBDEC_OP_AAJ : BBDEC_OP_DAJ);
  endproperty
  a_adjust: assert property (p_adjust) else $error("adjust misdecoded");
  property p_swap;
    op1 && byte_data[7:3] == 5'b10010 |=> dec_valid && dec_op == BBDEC_OP_SWAP
      && dec_reg == $past(byte_data[2:0]);
  endproperty
  a_swap: assert property (p_swap) else $error("short swap misdecoded");
  property p_inc;
    op1 && byte_data[7:3] == 5'b01000 |=> dec_op == BBDEC_OP_INC && dec_word
      && dec_reg == $past(byte_data[2:0]);
  endproperty
  a_inc: assert property (p_inc) else $error("short inc misdecoded");
  property p_len;
    $rose(dec_valid) |-> dec_len == cnt_q;
  endproperty
  a_len: assert property (p_len) else $error("length differs from bytes taken");
  property p_sext;
    dec_valid && dec_imm_sext |-> dec_imm[15:8] == {8{dec_imm[7]}};
  endproperty
  a_sext: assert property (p_sext) else $error("immediate not sign extended");
  property p_hold;
    dec_valid && !dec_ready |=> dec_valid && $stable(dec_op) && $stable(dec_imm) && $stable(dec_len);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed while held");
  property p_mul;
    dec_valid && (dec_op == BBDEC_OP_MULU || dec_op == BBDEC_OP_MULS) |-> dec_signed == (dec_op == BBDEC_OP_MULS);
  endproperty
  a_mul: assert property (p_mul) else $error("product signedness wrong");
  property p_div;
    dec_valid && (dec_op == BBDEC_OP_DIVU || dec_op == BBDEC_OP_DIVS) |-> dec_signed == (dec_op == BBDEC_OP_DIVS);
  endproperty
  a_div: assert property (p_div) else $error("quotient signedness wrong");
  property p_test;
    dec_valid && dec_op == BBDEC_OP_TEST |-> !dec_wb && dec_flags_wr;
  endproperty
  a_test: assert property (p_test) else $error("flag-only and writes back");
  c_sext: cover property (dec_valid && dec_imm_sext);
  c_stall: cover property (dec_valid && !dec_ready);
  c_test: cover property (dec_valid && dec_op == BBDEC_OP_TEST);
endmodule
bind bbdec_top bbdec_checker CHK (.clk, .rst, .byte_valid, .byte_ready, .byte_data, .dec_valid, .dec_ready,
  .dec_op, .dec_word, .dec_wb, .dec_flags_wr, .dec_signed, .dec_imm_sext, .dec_imm, .dec_reg, .dec_len);
`default_nettype wire

/* File: dv/bbdec_top_tb.sv */
// Self-checking bench for the opcode decoder
`timescale 1ns/1ns
`default_nettype none
module bbdec_top_tb;
  import bbdec_pkg::*;
  logic clk, rst, dec_ready, byte_valid, byte_ready, dec_valid, dec_word, dec_reg_dest, dec_wb;
  logic dec_flags_wr, dec_signed, dec_imm_sext, dec_imm_valid, dec_port_var, dec_count_reg;
  logic [7:0] byte_data;
  logic [15:0] dec_imm, dec_disp;
  logic [1:0] dec_mode;
  logic [2:0] dec_reg, dec_rm;
  logic [3:0] dec_len;
  bbdec_op_t dec_op;
  int miscompares, compares, cyc;
  bbdec_top DUT (.clk, .rst, .byte_valid, .byte_ready, .byte_data, .dec_valid, .dec_ready, .dec_op,
    .dec_word, .dec_reg_dest, .dec_wb, .dec_flags_wr, .dec_signed, .dec_imm_sext, .dec_imm_valid,
    .dec_imm, .dec_disp, .dec_port_var, .dec_count_reg, .dec_mode, .dec_reg, .dec_rm, .dec_len);
  bbdec_feed FEED (.clk, .rst, .byte_ready, .byte_valid, .byte_data);
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic results();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Cut a hang short well above the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] exp_imm(input logic [7:0] b, input logic sx);
    return sx ? {{8{b[7]}}, b} : {8'h00, b};
  endfunction
  // Consumer stalls a while, then takes the result
  task automatic rel();
    logic [15:0] h;
    h = dec_imm;
    repeat ($urandom_range(3))
    begin
      @(negedge clk);
      chk({dec_valid, byte_ready, dec_imm}, {2'b10, h});
    end
    dec_ready = 1'b1;
    @(negedge clk);
    dec_ready = 1'b0;
    chk(dec_valid, 1'b0);
  endtask
  // Bytes in v are listed opcode first; w of 2 leaves the width unchecked
  task automatic run(input logic [47:0] v, input int n, input bbdec_op_t op, input int w, input bit x);
    int k;
    for (k = n - 1; k >= 0; k--)
      FEED.q.push_back(v[8*k +: 8]);
    k = 0;
    while (dec_valid !== 1'b1 && k < 60)
    begin
      @(negedge clk);
      k++;
    end
    chk(dec_valid, 1'b1);
    chk(dec_op, op);
    chk(dec_len, n);
    if (w < 2)
      chk(dec_word, w[0]);
    if (!x)
      rel();
  endtask
  initial
  begin
    logic [31:0] r;
    rst = 1'b1;
    dec_ready = 1'b0;
    r = $urandom(32'h67245c63);
    repeat (2) @(negedge clk);
    chk({byte_ready, dec_valid}, 2'b10);
    rst = 1'b0;
    run(48'h86c1, 2, BBDEC_OP_SWAP, 0, 1);
    chk({dec_mode, dec_reg, dec_rm}, 8'hc1);
    chk({dec_imm_valid, dec_reg_dest}, 2'b01);
    rel();
    run(48'h42, 1, BBDEC_OP_INC, 1, 0);
    run(48'hfe060010, 4, BBDEC_OP_INC, 0, 1);
    chk(dec_disp, 16'h1000);
    rel();
    run(48'h9f, 1, BBDEC_OP_F2AH, 2, 1);
    chk({dec_wb, dec_flags_wr}, 2'b10);
    rel();
    run(48'h9e, 1, BBDEC_OP_AH2F, 2, 1);
    chk({dec_wb, dec_flags_wr}, 2'b01);
    rel();
    run(48'hd7, 1, BBDEC_OP_XLT, 2, 0);
    run(48'h98, 1, BBDEC_OP_SXB, 1, 0);
    run(48'h99, 1, BBDEC_OP_SXW, 1, 0);
    run(48'hac, 1, BBDEC_OP_SLD, 0, 0);
    run(48'hab, 1, BBDEC_OP_SST, 1, 0);
    run(48'h37, 1, BBDEC_OP_AAJ, 2, 0);
    run(48'h27, 1, BBDEC_OP_DAJ, 2, 0);
    run(48'hec, 1, BBDEC_OP_PIN, 2, 1);
    chk(dec_port_var, 1'b1);
    rel();
    run(48'he420, 2, BBDEC_OP_PIN, 2, 1);
    chk(dec_port_var, 1'b0);
    rel();
    run(48'h84c3, 2, BBDEC_OP_TEST, 0, 0);
    run(48'hf6e1, 2, BBDEC_OP_MULU, 0, 0);
    run(48'hf7e9, 2, BBDEC_OP_MULS, 1, 0);
    run(48'hf6f1, 2, BBDEC_OP_DIVU, 0, 0);
    run(48'hf7f9, 2, BBDEC_OP_DIVS, 1, 0);
    run(48'hd3e0, 2, BBDEC_OP_SHR, 1, 1);
    chk(dec_count_reg, 1'b1);
    rel();
    run(48'hd0e0, 2, BBDEC_OP_SHR, 0, 1);
    chk(dec_count_reg, 1'b0);
    rel();
    run(48'hf666f0, 3, BBDEC_OP_MULU, 0, 1);
    chk({dec_mode, dec_rm, dec_disp}, {5'b01110, 16'hfff0});
    rel();
    // Immediates with random data, sign-extended and word forms
    repeat (12)
    begin
      r = $urandom;
      run({8'h24, r[7:0]}, 2, BBDEC_OP_AND, 0, 1);
      chk(dec_imm, exp_imm(r[7:0], 1'b0));
      rel();
      run({8'h25, r[15:0]}, 3, BBDEC_OP_AND, 1, 1);
      chk(dec_imm, {r[7:0], r[15:8]});
      rel();
      run({8'h14, r[7:0]}, 2, BBDEC_OP_ADC, 0, 0);
      run({16'h83d0, r[23:16]}, 3, BBDEC_OP_ADC, 1, 1);
      chk({dec_imm_sext, dec_imm}, {1'b1, exp_imm(r[23:16], 1'b1)});
      chk({dec_imm_valid, dec_reg_dest}, 2'b10);
      rel();
      run({16'h81d0, r[15:0]}, 4, BBDEC_OP_ADC, 1, 0);
      run({8'h2d, r[15:0]}, 3, BBDEC_OP_SUB, 1, 0);
      run({16'h81e8, r[15:0]}, 4, BBDEC_OP_SUB, 1, 0);
      run({16'h80e8, r[7:0]}, 3, BBDEC_OP_SUB, 0, 0);
      run({5'b10010, r[26:24]}, 1, BBDEC_OP_SWAP, 1, 1);
      chk(dec_reg, r[26:24]);
      rel();
    end
    results();
  end
endmodule
`default_nettype wire
